// >>> logic/cpu_status_flag_register.sv
// Processor flag register with APB access and datapath flag updates
// What this block does
// - Timeout flag set on power-up/clear/sleep; watchdog clears
// - Powerdown flag set power-up/clear; sleep clears it
// - Digit carry from bit three carry-out
// - Carry from most significant bit carry-out
// - Add and subtract instructions update both carries
// - Subtract adds two's complement of second operand
// - Rotates load carry from shifted-out bit
// - Prescaler on watchdog gives timer 1:1
// - Flag-writing instruction keeps computed flags
// - Software cannot write timeout or powerdown
// - Subtract carries mean no borrow when set
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module cpu_status_flag_register
	import flags_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Datapath
	input wire alu_req_t alu_req,
	input wire power_evt_t power_evt,
	output logic [7:0] alu_result,
	// Bank and prescaler outputs
	output logic [1:0] direct_bank_select,
	output logic indirect_bank_bit,
	output logic [1:0] direct_bank,
	output logic [1:0] indirect_bank_pair,
	output logic timer_prescale_bypass
);
	// ==========================================================
	// State
	logic [7:0] processor_flags;
	logic [7:0] ctrl;
	logic [8:0] sum;
	logic [4:0] nibble_sum;
	logic [7:0] operand_b;
	logic [7:0] result;
	logic next_carry;
	logic next_digit;
	logic affects_carries;
	logic affects_zero;
	logic wr_flags;
	logic wr_ctrl;

	assign pready = 1'b1;
	assign wr_flags = psel && penable && pwrite && (paddr == flags_addr);
	assign wr_ctrl = psel && penable && pwrite && (paddr == ctrl_addr);
	assign pslverr = psel && penable && (paddr != flags_addr) && (paddr != ctrl_addr);

	// ==========================================================
	// Arithmetic flags
	always_comb begin
		// Subtract stores no borrow as a set carry, so adding ~b + 1 gives both carries for free
		operand_b = (alu_req.op == op_sub) ? ~alu_req.b : alu_req.b;
		sum = {1'b0, alu_req.a} + {1'b0, operand_b} + {8'h00, alu_req.op == op_sub};
		nibble_sum = {1'b0, alu_req.a[3:0]} + {1'b0, operand_b[3:0]} + {4'h0, alu_req.op == op_sub};
		next_carry = processor_flags[carry_pos];
		next_digit = processor_flags[digit_pos];
		result = sum[7:0];
		affects_carries = 1'b0;
		affects_zero = 1'b0;
		unique case (alu_req.op)
			op_add, op_sub: begin
				next_carry = sum[8];
				next_digit = nibble_sum[4];
				affects_carries = 1'b1;
				affects_zero = 1'b1;
			end
			op_logic: begin
				result = alu_req.a;
				affects_zero = 1'b1;
			end
			op_rot_left: begin
				result = {alu_req.a[6:0], processor_flags[carry_pos]};
				next_carry = alu_req.a[7];
				affects_carries = 1'b1;
			end
			op_rot_right: begin
				result = {processor_flags[carry_pos], alu_req.a[7:1]};
				next_carry = alu_req.a[0];
				affects_carries = 1'b1;
			end
			default: begin
				result = alu_req.a;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alu_result <= 8'h00;
		end else begin
			alu_result <= result;
		end
	end

	// ==========================================================
	// Flag register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			processor_flags <= flags_reset;
		end else begin
			if (alu_req.dest_flags) begin
				processor_flags[irp_pos] <= alu_req.write_data[irp_pos];
				processor_flags[rp_hi_pos] <= alu_req.write_data[rp_hi_pos];
				processor_flags[rp_lo_pos] <= alu_req.write_data[rp_lo_pos];
				processor_flags[zero_pos] <= alu_req.write_data[zero_pos];
				processor_flags[digit_pos] <= alu_req.write_data[digit_pos];
				processor_flags[carry_pos] <= alu_req.write_data[carry_pos];
			end else if (wr_flags) begin
				// Timeout and powerdown stay out of reach of software
				processor_flags[7:5] <= pwdata[7:5];
				processor_flags[2:0] <= pwdata[2:0];
			end
			// Computed flags win over the data write to the same bits
			if (affects_zero) begin
				processor_flags[zero_pos] <= (result == 8'h00);
			end
			if (affects_carries) begin
				processor_flags[carry_pos] <= next_carry;
				if (alu_req.op == op_add || alu_req.op == op_sub) begin
					processor_flags[digit_pos] <= next_digit;
				end
			end
			// Expiry wins over instructions in the same cycle
			if (power_evt.watchdog_expired) begin
				processor_flags[to_pos] <= 1'b0;
			end else if (power_evt.watchdog_clear_instruction || power_evt.sleep_instruction) begin
				processor_flags[to_pos] <= 1'b1;
			end
			if (power_evt.sleep_instruction) begin
				processor_flags[pd_pos] <= 1'b0;
			end else if (power_evt.watchdog_clear_instruction) begin
				processor_flags[pd_pos] <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= ctrl_reset;
		end else if (wr_ctrl) begin
			ctrl <= {7'h00, pwdata[psa_pos]};
		end
	end

	// ==========================================================
	// Read data and outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= (paddr == flags_addr) ? {24'h000000, processor_flags} :
				(paddr == ctrl_addr) ? {24'h000000, ctrl} : 32'h00000000;
		end
	end

	assign direct_bank_select = processor_flags[rp_hi_pos:rp_lo_pos];
	assign indirect_bank_bit = processor_flags[irp_pos];
	assign direct_bank = processor_flags[rp_hi_pos:rp_lo_pos];
	assign indirect_bank_pair = {processor_flags[irp_pos], 1'b0};
	assign timer_prescale_bypass = ctrl[psa_pos];

	// ==========================================================
	// Checks
	a_sleep_clears_pd: assert property (@(posedge clk) disable iff (!rst_n)
		power_evt.sleep_instruction |=> !processor_flags[pd_pos]) else $error("pd not cleared");
	a_wdt_clears_to: assert property (@(posedge clk) disable iff (!rst_n)
		power_evt.watchdog_expired |=> !processor_flags[to_pos]) else $error("to not cleared");
	a_clr_sets_to: assert property (@(posedge clk) disable iff (!rst_n)
		power_evt.watchdog_clear_instruction && !power_evt.watchdog_expired && !power_evt.sleep_instruction
		|=> processor_flags[to_pos] && processor_flags[pd_pos]) else $error("clear failed");
	a_add_carry: assert property (@(posedge clk) disable iff (!rst_n)
		alu_req.op == op_add |=> processor_flags[carry_pos] == $past(sum[8])) else $error("bad carry");
	a_sub_noborrow: assert property (@(posedge clk) disable iff (!rst_n)
		alu_req.op == op_sub |=> processor_flags[carry_pos] == ($past(alu_req.a) >= $past(alu_req.b)))
		else $error("bad borrow");
	a_digit_carry: assert property (@(posedge clk) disable iff (!rst_n)
		alu_req.op == op_add |=> processor_flags[digit_pos] ==
		($past(alu_req.a[3:0]) + $past(alu_req.b[3:0]) > 5'h0f)) else $error("bad digit carry");
	a_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
		alu_req.op == op_logic |=> processor_flags[zero_pos] == ($past(alu_req.a) == 8'h00))
		else $error("bad zero");
	a_rot_carry: assert property (@(posedge clk) disable iff (!rst_n)
		alu_req.op == op_rot_left |=> processor_flags[carry_pos] == $past(alu_req.a[7])) else $error("bad rotate");
	a_sw_no_to: assert property (@(posedge clk) disable iff (!rst_n)
		wr_flags && power_evt == 3'b000 |=> $stable(processor_flags[4:3])) else $error("to/pd written");
endmodule : cpu_status_flag_register

// >>> common/flags_pkg.sv
// Package for the processor flag register block
package flags_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] flags_index = 8'h03;
	localparam logic [11:0] flags_addr = 12'h00c;
	localparam logic [11:0] ctrl_addr = 12'h010;
	// ==========================================================
	// Field positions
	localparam int carry_pos = 0;
	localparam int digit_pos = 1;
	localparam int zero_pos = 2;
	localparam int pd_pos = 3;
	localparam int to_pos = 4;
	localparam int rp_lo_pos = 5;
	localparam int rp_hi_pos = 6;
	localparam int irp_pos = 7;
	localparam int psa_pos = 0;
	// ==========================================================
	// Reset values
	localparam logic [7:0] flags_reset = 8'h18;
	localparam logic [7:0] ctrl_reset = 8'h00;
	// ==========================================================
	// Datapath operations
	typedef enum logic [2:0] {
		op_none = 3'b000,
		op_add = 3'b001,
		op_sub = 3'b010,
		op_logic = 3'b011,
		op_rot_left = 3'b100,
		op_rot_right = 3'b101
	} alu_op_t;
	typedef struct packed {
		alu_op_t op;
		logic [7:0] a;
		logic [7:0] b;
		logic dest_flags;
		logic [7:0] write_data;
	} alu_req_t;
	typedef struct packed {
		logic watchdog_clear_instruction;
		logic sleep_instruction;
		logic watchdog_expired;
	} power_evt_t;
endpackage : flags_pkg

// >>> test/core_model.sv
// Behavioural model of the instruction datapath that drives the flag block
`timescale 1ns/1ps
module core_model
	import flags_pkg::*;
(
	// Clock
	input wire logic clk,
	// Datapath requests
	output alu_req_t alu_req,
	output power_evt_t power_evt
);
	// ==========================================
	// Requests
	initial begin
		alu_req = '0;
		power_evt = '0;
	end
	// Operands are scrambled when idle so a stale value is never mistaken for a live one
	task automatic issue(input alu_op_t o, input logic [7:0] a, input logic [7:0] b, input logic d,
		input logic [7:0] wd);
		alu_req <= '{o, a, b, d, wd};
		@(posedge clk);
		alu_req <= '{op_none, ~a, ~b, 1'b0, ~wd};
	endtask : issue
	task automatic pulse(input power_evt_t e);
		power_evt <= e;
		@(posedge clk);
		power_evt <= '0;
	endtask : pulse
endmodule : core_model

// >>> test/test_cpu_status_flag_register.sv
// Self-checking bench for the processor flag register
`timescale 1ns/1ps
module test_cpu_status_flag_register;
	import flags_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, ibb, tpb, serr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, expq[$];
	alu_req_t alu_req;
	power_evt_t power_evt;
	logic [7:0] alu_result, sh, d;
	logic [1:0] dbs, db, ibp;
	int err_total, cmp_count, cyc;
	alu_op_t o;
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	cpu_status_flag_register dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .alu_req(alu_req),
		.power_evt(power_evt), .alu_result(alu_result), .direct_bank_select(dbs), .indirect_bank_bit(ibb),
		.direct_bank(db), .indirect_bank_pair(ibp), .timer_prescale_bypass(tpb));
	core_model cm_u (.clk(clk), .alu_req(alu_req), .power_evt(power_evt));
	// ==========================================
	// Checking
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task test_done;
		$display("errors=%0d compares=%0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			err_total++;
			test_done();
		end
	end
	// Read data is judged against the oldest note at the access edge
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) chk(prdata, expq.pop_front());
	end
	// ==========================================
	// Bus and datapath tasks
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] e);
		expq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task op(input alu_op_t o, input logic [7:0] a, input logic [7:0] b, input logic dst, input logic [7:0] wd);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] r;
		r = a;
		s = (o == op_sub) ? {1'b0, a} + {1'b0, ~b} + 9'h001 : {1'b0, a} + {1'b0, b};
		h = (o == op_sub) ? {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01 : {1'b0, a[3:0]} + {1'b0, b[3:0]};
		if (dst) sh = {wd[7:5], sh[4:0]};
		case (o)
			op_add, op_sub: begin
				r = s[7:0];
				sh[2:0] = {s[7:0] == 8'h00, h[4], s[8]};
			end
			op_logic: sh[2] = (a == 8'h00);
			op_rot_left: {sh[0], r} = {a, sh[0]};
			op_rot_right: {r, sh[0]} = {sh[0], a};
			default: ;
		endcase
		cm_u.issue(o, a, b, dst, wd);
		#1 chk({24'h0, alu_result}, {24'h0, r});
		@(posedge clk);
		rd(flags_addr, {24'h0, sh});
	endtask : op
	// ==========================================
	// Main sequence
	initial begin
		{rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(9020));
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		sh = flags_reset;
		rd(flags_addr, 32'h18);
		rd(ctrl_addr, 32'h0);
		rd(12'h020, 32'h0);
		chk(serr, 1'b1);
		// Bank bits through every direct value; timeout and powerdown must survive
		for (int i = 0; i < 4; i++) begin
			d = {$urandom % 2, i[1:0], 5'($urandom)};
			apb(1'b1, flags_addr, {24'h0, d});
			sh = {d[7:5], sh[4:3], d[2:0]};
			chk({ibp, db, dbs, ibb}, {d[7], 1'b0, d[6:5], d[6:5], d[7]});
			rd(flags_addr, {24'h0, sh});
		end
		apb(1'b1, ctrl_addr, 32'h1);
		chk(tpb, 1'b1);
		apb(1'b1, ctrl_addr, 32'h0);
		chk(tpb, 1'b0);
		// Carry and zero boundaries, then random traffic
		op(op_add, 8'hff, 8'h01, 1'b0, 8'h00);
		op(op_sub, 8'h05, 8'h05, 1'b1, 8'hff);
		op(op_sub, 8'h00, 8'h01, 1'b0, 8'h00);
		op(op_logic, 8'h00, 8'h33, 1'b0, 8'h00);
		for (int i = 0; i < 30; i++) begin
			o = alu_op_t'(3'($urandom % 5 + 1));
			op(o, 8'($urandom), 8'($urandom), (o == op_add || o == op_sub) && ($urandom % 2), 8'($urandom));
		end
		// Power events: expiry, clear, sleep
		cm_u.pulse('{1'b0, 1'b0, 1'b1});
		sh[4] = 1'b0;
		rd(flags_addr, {24'h0, sh});
		cm_u.pulse('{1'b1, 1'b0, 1'b0});
		sh[4:3] = 2'b11;
		rd(flags_addr, {24'h0, sh});
		cm_u.pulse('{1'b0, 1'b1, 1'b0});
		sh[4:3] = 2'b10;
		rd(flags_addr, {24'h0, sh});
		test_done();
	end
endmodule : test_cpu_status_flag_register
